// File: logic/asc_cfg.svh
// Purpose: offsets, field positions, reset values and counts of the adc status/config bank
// Assumes: register index i sits at byte address 4*i on apb
// Notes:   definitions only
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
`define ASC_IDX_STATUS    8'h00
`define ASC_IDX_GENERAL   8'h01
`define ASC_IDX_DATA      8'h02
`define ASC_IDX_IRQ_STAT  8'h03
`define ASC_IDX_IRQ_MASK  8'h04
`define ASC_STATUS_RST    8'h81
`define ASC_GENERAL_RST   8'h00
`define ASC_DATA_RST      8'h00
`define ASC_CRC_IN_RST    1'b0
`define ASC_BOR_RST       1'b1
`define ASC_GENERAL_WMASK 8'hce
`define ASC_DATA_WMASK    8'hb3
`define ASC_ST_TOP        7
`define ASC_ST_SEQ        6
`define ASC_ST_FUSE       2
`define ASC_ST_CRC        1
`define ASC_ST_BOR        0
`define ASC_GEN_REF       7
`define ASC_GEN_CRC       6
`define ASC_GEN_RANGE     3
`define ASC_GEN_FORCE     2
`define ASC_GEN_CAL       1
`define ASC_GEN_SRST      0
`define ASC_DAT_PAT       7
`define ASC_DAT_APP_HI    5
`define ASC_DAT_APP_LO    4
`define ASC_FIXED_CODE    16'ha5a5
`define ASC_IRQ_CRC       0
`define ASC_IRQ_BOR       1
`define ASC_IRQ_CAL       2
`define ASC_IRQ_WIDTH     3
`define ASC_FUSE_SETTLE   2'h3
`endif

// File: logic/asc_pkg.sv
// Purpose: shared types of the adc status/config bank
// Assumes: nothing
// Notes:   constants live in asc_cfg.svh
package asc_pkg;
   typedef logic [7:0]  asc_byte_t;
   typedef logic [15:0] asc_sample_t;
   typedef logic [19:0] asc_word_t;
   typedef enum logic [1:0] {
      ASC_APP_NONE = 2'h0,
      ASC_APP_CHAN = 2'h1,
      ASC_APP_STAT = 2'h2,
      ASC_APP_RSVD = 2'h3
   } asc_append_e;
endpackage : asc_pkg

// File: logic/asc_regs.sv
// Purpose: status, general and data-output configuration registers of an 8-channel adc, on apb
// Assumes: pclk 100 MHz; spi clock and its crc-error line, brownout and supply pins are async
// Notes:   one access cycle per transfer; irq status/mask added for event reporting
//
// The APB slave port was chosen for this implementation.
`include "asc_cfg.svh"

module asc_regs (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                spi_sclk,
   input  wire logic                spi_crc_err,
   input  wire logic                brownout_pin,
   input  wire logic                analog_supply_cycle,
   input  wire logic                sequencer_running,
   input  wire logic                config_load_crc_bad,
   input  wire logic                cal_done,
   input  wire asc_pkg::asc_sample_t adc_result,
   input  wire logic [3:0]          adc_chan,
   output asc_pkg::asc_word_t       out_word,
   output logic                     ref_enable,
   output logic                     crc_enable,
   output logic                     range_2x,
   output logic                     force_all_analog,
   output logic                     cal_active,
   output logic                     test_pattern_out,
   output logic [1:0]               append_sel,
   output logic [1:0]               spi_clock_format,
   output logic                     irq
);
   import asc_pkg::*;

   function automatic logic [31:0] asc_addr(input logic [7:0] idx);
      asc_addr = {22'h0, idx, 2'b00};
   endfunction : asc_addr

   // set wins over a clear arriving in the same cycle
   function automatic logic [2:0] asc_sticky(input logic [2:0] cur,
                                             input logic [2:0] set,
                                             input logic [2:0] clr);
      asc_sticky = set | (cur & ~clr);
   endfunction : asc_sticky

   asc_byte_t   gen_reg;
   asc_byte_t   gen_next;
   asc_byte_t   data_reg;
   asc_byte_t   data_next;
   logic        crc_fault_reg;
   logic        bor_reg;
   logic        fuse_fault_reg;
   logic        fuse_pend_reg;
   logic [1:0]  fuse_cnt_reg;
   logic [2:0]  irq_st_reg;
   logic [2:0]  irq_mask_reg;
   logic [3:0]  pin_s1_reg;
   logic [3:0]  pin_s2_reg;
   logic [3:0]  pin_s3_reg;
   logic [3:0]  pin_f_reg;
   logic [3:0]  pin_f_next;
   logic [3:0]  pin_fd_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   asc_word_t   out_word_reg;
   asc_word_t   out_word_next;
   logic        irq_reg;

   // pin bundle: 0 spi clock, 1 crc error line, 2 brownout, 3 supply cycle
   wire [3:0] pin_raw  = {analog_supply_cycle, brownout_pin, spi_crc_err, spi_sclk};
   // a change counts once the second and third stages agree
   assign pin_f_next = (pin_s2_reg & pin_s3_reg) | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
   wire [3:0] pin_rise = pin_f_reg & ~pin_fd_reg;
   wire [3:0] pin_fall = ~pin_f_reg & pin_fd_reg;

   // sampling edge follows the programmed spi mode: modes 0 and 3 sample on rise
   wire samp_rise   = (data_reg[1] == data_reg[0]);
   wire samp_edge   = samp_rise ? pin_rise[0] : pin_fall[0];
   wire crc_set     = samp_edge & pin_f_reg[1] & gen_reg[`ASC_GEN_CRC];
   wire bor_set     = pin_rise[2] | pin_rise[3];
   wire supply_rise = pin_rise[3];

   wire setup_ph  = psel & ~penable;
   wire wr_fire   = psel & penable & pready_reg & pwrite;
   wire rd_fire   = psel & penable & pready_reg & ~pwrite;
   wire is_st     = (paddr == asc_addr(`ASC_IDX_STATUS));
   wire is_gen    = (paddr == asc_addr(`ASC_IDX_GENERAL));
   wire is_data   = (paddr == asc_addr(`ASC_IDX_DATA));
   wire is_ist    = (paddr == asc_addr(`ASC_IDX_IRQ_STAT));
   wire is_imask  = (paddr == asc_addr(`ASC_IDX_IRQ_MASK));
   wire mapped    = is_st | is_gen | is_data | is_ist | is_imask;
   wire wr_allow  = ~crc_fault_reg | is_st | is_gen;
   wire wr_ok     = wr_fire & mapped & wr_allow;
   wire srst      = wr_ok & is_gen & pwdata[`ASC_GEN_SRST];
   wire st_wr     = wr_ok & is_st;
   wire crc_clr   = st_wr & pwdata[`ASC_ST_CRC];
   wire bor_clr   = st_wr & pwdata[`ASC_ST_BOR];
   wire fuse_take = fuse_pend_reg & (fuse_cnt_reg == 2'h0);
   wire cal_fin   = cal_done & gen_reg[`ASC_GEN_CAL];

   wire [2:0] irq_evt = {cal_fin, bor_set, crc_set};
   wire [2:0] irq_clr = (wr_ok & is_ist) ? pwdata[2:0] : 3'h0;
   wire [3:0] stat_flags = {sequencer_running, fuse_fault_reg, crc_fault_reg, bor_reg};

   wire asc_byte_t status_rd = {1'b1, sequencer_running, 3'h0,
                                fuse_fault_reg, crc_fault_reg, bor_reg};
   wire asc_byte_t gen_rd    = gen_reg & `ASC_GENERAL_WMASK;
   wire asc_byte_t data_rd   = data_reg & `ASC_DATA_WMASK;
   wire [31:0] rd_mux = is_st    ? {24'h0, status_rd} :
                        is_gen   ? {24'h0, gen_rd} :
                        is_data  ? {24'h0, data_rd} :
                        is_ist   ? {29'h0, irq_st_reg} :
                        is_imask ? {29'h0, irq_mask_reg} : 32'h0;
   wire slverr_now = ~mapped | (pwrite & ~wr_allow);

   always_comb
   begin
      gen_next = gen_reg;
      if (cal_fin)
         gen_next[`ASC_GEN_CAL] = 1'b0;
      if (wr_ok && is_gen)
         gen_next = pwdata[7:0] & `ASC_GENERAL_WMASK;
      if (srst)
         gen_next = `ASC_GENERAL_RST;
   end

   always_comb
   begin
      data_next = data_reg;
      if (wr_ok && is_data)
         data_next = pwdata[7:0] & `ASC_DATA_WMASK;
   end

   always_comb
   begin
      out_word_next[19:4] = data_reg[`ASC_DAT_PAT] ? `ASC_FIXED_CODE : adc_result;
      unique case (asc_append_e'(data_reg[`ASC_DAT_APP_HI:`ASC_DAT_APP_LO]))
         ASC_APP_NONE: out_word_next[3:0] = 4'h0;
         ASC_APP_CHAN: out_word_next[3:0] = adc_chan;
         ASC_APP_STAT: out_word_next[3:0] = stat_flags;
         ASC_APP_RSVD: out_word_next[3:0] = 4'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_reg <= 4'h0;
         pin_s2_reg <= 4'h0;
         pin_s3_reg <= 4'h0;
         pin_f_reg  <= 4'h0;
         pin_fd_reg <= 4'h0;
      end
      else
      begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_f_reg  <= pin_f_next;
         pin_fd_reg <= pin_f_reg;
      end
   end

   // soft reset returns configuration to defaults in the same edge as the write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gen_reg  <= `ASC_GENERAL_RST;
         data_reg <= `ASC_DATA_RST;
      end
      else
      begin
         gen_reg  <= gen_next;
         data_reg <= srst ? `ASC_DATA_RST : data_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         crc_fault_reg <= `ASC_CRC_IN_RST;
         bor_reg       <= `ASC_BOR_RST;
      end
      else
      begin
         crc_fault_reg <= srst ? crc_set : (crc_set | (crc_fault_reg & ~crc_clr));
         bor_reg       <= srst | bor_set | (bor_reg & ~bor_clr);
      end
   end

   // fuse result is sampled a few cycles after each trigger so the checker settles
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fuse_pend_reg  <= 1'b1;
         fuse_cnt_reg   <= `ASC_FUSE_SETTLE;
         fuse_fault_reg <= 1'b0;
      end
      else if (srst || supply_rise)
      begin
         fuse_pend_reg <= 1'b1;
         fuse_cnt_reg  <= `ASC_FUSE_SETTLE;
      end
      else if (fuse_take)
      begin
         fuse_pend_reg  <= 1'b0;
         fuse_fault_reg <= config_load_crc_bad;
      end
      else if (fuse_pend_reg)
         fuse_cnt_reg <= fuse_cnt_reg - 2'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_st_reg   <= 3'h0;
         irq_mask_reg <= 3'h0;
         irq_reg      <= 1'b0;
      end
      else
      begin
         irq_st_reg   <= srst ? irq_evt : asc_sticky(irq_st_reg, irq_evt, irq_clr);
         irq_mask_reg <= srst ? 3'h0 : ((wr_ok && is_imask) ? pwdata[2:0] : irq_mask_reg);
         irq_reg      <= |(irq_st_reg & irq_mask_reg);
      end
   end

   // read data and error are formed in setup so the access phase completes at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg   <= 32'h0;
         pready_reg   <= 1'b0;
         pslverr_reg  <= 1'b0;
         out_word_reg <= 20'h0;
      end
      else
      begin
         prdata_reg   <= (setup_ph && !pwrite) ? rd_mux : 32'h0;
         pready_reg   <= setup_ph;
         pslverr_reg  <= setup_ph & slverr_now;
         out_word_reg <= out_word_next;
      end
   end

   assign prdata           = prdata_reg;
   assign pready           = pready_reg;
   assign pslverr          = pslverr_reg;
   assign out_word         = out_word_reg;
   assign ref_enable       = gen_reg[`ASC_GEN_REF];
   assign crc_enable       = gen_reg[`ASC_GEN_CRC];
   assign range_2x         = gen_reg[`ASC_GEN_RANGE];
   assign force_all_analog = gen_reg[`ASC_GEN_FORCE];
   assign cal_active       = gen_reg[`ASC_GEN_CAL];
   assign test_pattern_out = data_reg[`ASC_DAT_PAT];
   assign append_sel       = data_reg[`ASC_DAT_APP_HI:`ASC_DAT_APP_LO];
   assign spi_clock_format = data_reg[1:0];
   assign irq              = irq_reg;

   property p_top_one;
      @(posedge pclk) disable iff (!presetn)
      rd_fire && is_st |-> prdata[`ASC_ST_TOP];
   endproperty
   a_top_one: assert property (p_top_one) else $error("status top bit read zero");

   property p_seq_seen;
      @(posedge pclk) disable iff (!presetn)
      setup_ph && !pwrite && is_st ##1 rd_fire |-> prdata[`ASC_ST_SEQ] == $past(sequencer_running);
   endproperty
   a_seq_seen: assert property (p_seq_seen) else $error("sequencer bit wrong");

   property p_fuse_hold;
      @(posedge pclk) disable iff (!presetn)
      fuse_fault_reg != $past(fuse_fault_reg) |-> $past(fuse_take);
   endproperty
   a_fuse_hold: assert property (p_fuse_hold) else $error("fuse fault moved unprompted");

   property p_fuse_recheck;
      @(posedge pclk) disable iff (!presetn)
      srst |=> fuse_pend_reg ##1 fuse_pend_reg ##[1:4] !fuse_pend_reg;
   endproperty
   a_fuse_recheck: assert property (p_fuse_recheck) else $error("fuse not rechecked");

   property p_crc_set;
      @(posedge pclk) disable iff (!presetn)
      crc_set |=> crc_fault_reg && irq_st_reg[`ASC_IRQ_CRC];
   endproperty
   a_crc_set: assert property (p_crc_set) else $error("crc fault not set");

   property p_blocked;
      @(posedge pclk) disable iff (!presetn)
      wr_fire && crc_fault_reg && is_data |-> pslverr ##1 $stable(data_reg);
   endproperty
   a_blocked: assert property (p_blocked) else $error("write passed while blocked");

   property p_bor_set;
      @(posedge pclk) disable iff (!presetn)
      bor_set |=> bor_reg;
   endproperty
   a_bor_set: assert property (p_bor_set) else $error("brownout not set");

   property p_cal_end;
      @(posedge pclk) disable iff (!presetn)
      cal_fin && !(wr_ok && is_gen) |=> !cal_active;
   endproperty
   a_cal_end: assert property (p_cal_end) else $error("calibration bit stuck");

   property p_soft_reset;
      @(posedge pclk) disable iff (!presetn)
      srst |=> gen_reg == `ASC_GENERAL_RST && data_reg == `ASC_DATA_RST && bor_reg;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

   property p_pattern;
      @(posedge pclk) disable iff (!presetn)
      data_reg[`ASC_DAT_PAT] |=> out_word[19:4] == `ASC_FIXED_CODE;
   endproperty
   a_pattern: assert property (p_pattern) else $error("fixed code missing");

   property p_chan_tag;
      @(posedge pclk) disable iff (!presetn)
      data_reg[5:4] == 2'h1 |=> out_word[3:0] == $past(adc_chan);
   endproperty
   a_chan_tag: assert property (p_chan_tag) else $error("channel tag wrong");

   property p_rsvd_zero;
      @(posedge pclk) disable iff (!presetn)
      rd_fire && is_gen |-> prdata[5:4] == 2'h0 && !prdata[`ASC_GEN_SRST];
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

   cv_soft_reset: cover property (@(posedge pclk) disable iff (!presetn) srst);
   cv_blocked:    cover property (@(posedge pclk) disable iff (!presetn)
                                  wr_fire && crc_fault_reg && is_data);
   cv_crc_clear:  cover property (@(posedge pclk) disable iff (!presetn)
                                  crc_fault_reg ##1 crc_clr ##1 !crc_fault_reg);
   cv_irq:        cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule : asc_regs

// File: test/asc_spi_host.sv
// Purpose: far-side spi host that clocks frames and raises the incoming crc error line
// Assumes: 160 ns link clock period, clock stands still between frames
// Notes:   error line is held high at every non-sampling edge to catch a wrong edge choice
module asc_spi_host (
   output logic sclk,
   output logic crc_err
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      sclk    = 1'b0;
      crc_err = 1'b0;
   end

   // idle level follows polarity; phase picks leading or trailing edge for sampling
   task automatic send_frame(input logic [1:0] mode, input logic err);
      int i;
      sclk = mode[1];
      #37;
      for (i = 0; i < 8; i++)
      begin
         crc_err = mode[0] ? 1'b1 : (err && i == 7);
         #5;
         sclk = !mode[1];
         #75;
         crc_err = mode[0] ? (err && i == 7) : 1'b1;
         #5;
         sclk = mode[1];
         #75;
      end
      crc_err = 1'b0;
   endtask : send_frame
endmodule : asc_spi_host

// File: test/tb_top.sv
// Purpose: self-checking bench for the adc status and configuration bank
// Assumes: apb slave answers with one access cycle, byte address is four times the index
// Notes:   apb results are noted in a queue and checked by a separate monitor
`define CHK(what, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("ERROR %s expected %h seen %h", what, exp, got); \
      end \
   end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic                 pclk = 1'b0;
   logic                 presetn = 1'b0;
   logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0]          paddr = '0, pwdata = '0, prdata;
   logic                 pready, pslverr, spi_sclk, spi_crc_err, irq;
   logic                 brownout_pin = 1'b0, analog_supply_cycle = 1'b0;
   logic                 sequencer_running = 1'b0, config_load_crc_bad = 1'b0;
   logic                 cal_done = 1'b0;
   asc_pkg::asc_sample_t adc_result = '0;
   logic [3:0]           adc_chan = '0;
   asc_pkg::asc_word_t   out_word;
   logic                 ref_enable, crc_enable, range_2x, force_all_analog, cal_active;
   logic                 test_pattern_out;
   logic [1:0]           append_sel, spi_clock_format;
   logic [33:0]          notes[$];
   logic [33:0]          note;
   logic [15:0]          exp_data;
   logic [3:0]           exp_tag;
   int                   num_errors = 0, comparisons = 0, seed = 73;
   wire  [4:0]           gen_outs = {ref_enable, crc_enable, range_2x, force_all_analog,
                                     cal_active};
   wire  [4:0]           dat_outs = {test_pattern_out, append_sel, spi_clock_format};

   always #5 pclk = ~pclk;

   asc_regs u_asc_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .spi_sclk, .spi_crc_err, .brownout_pin, .analog_supply_cycle,
      .sequencer_running, .config_load_crc_bad, .cal_done, .adc_result, .adc_chan,
      .out_word, .ref_enable, .crc_enable, .range_2x, .force_all_analog, .cal_active,
      .test_pattern_out, .append_sel, .spi_clock_format, .irq);

   asc_spi_host u_asc_spi_host (.sclk(spi_sclk), .crc_err(spi_crc_err));

   task automatic tally_and_finish;
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   // request is held until pready is seen high at a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] exp, input logic err);
      int n;
      notes.push_back({wr, err, 24'h0, exp});
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {24'h0, a};
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n++)
         @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 16)
      begin
         num_errors++;
         `CHK("pready", 1'b1, pready)
         tally_and_finish();
      end
   endtask : xfer

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic err);
      xfer(1'b0, a, 8'h00, exp, err);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic err);
      xfer(1'b1, a, d, 8'h00, err);
   endtask : wr

   // pins pass a synchroniser, so the pulse is held long enough to be seen
   task automatic bump(input logic sup);
      analog_supply_cycle <= sup;
      brownout_pin        <= !sup;
      repeat (4) @(posedge pclk);
      analog_supply_cycle <= 1'b0;
      brownout_pin        <= 1'b0;
      repeat (16) @(posedge pclk);
   endtask : bump

   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1)
      begin
         note = notes.pop_front();
         if (note[33])
            `CHK("pslverr", note[32], pslverr)
         else
            `CHK("read", note[32:0], {pslverr, prdata})
      end
   end

   initial
   begin
      int m;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(8'h00, 8'h81, 1'b0);
      rd(8'h04, 8'h00, 1'b0);
      rd(8'h08, 8'h00, 1'b0);
      rd(8'h14, 8'h00, 1'b1);
      sequencer_running   <= 1'b1;
      config_load_crc_bad <= 1'b1;
      wr(8'h00, 8'hff, 1'b0);
      rd(8'h00, 8'hc0, 1'b0);
      wr(8'h04, 8'hfe, 1'b0);
      rd(8'h04, 8'hce, 1'b0);
      `CHK("general outs", 5'h1f, gen_outs)
      cal_done <= 1'b1;
      @(posedge pclk);
      cal_done <= 1'b0;
      rd(8'h04, 8'hcc, 1'b0);
      wr(8'h08, 8'hff, 1'b0);
      rd(8'h08, 8'hb3, 1'b0);
      `CHK("data outs", 5'h1f, dat_outs)
      for (m = 0; m < 8; m++)
      begin
         wr(8'h08, {m[2], 1'b0, m[1:0], 4'h0}, 1'b0);
         adc_result <= 16'($random(seed));
         adc_chan   <= 4'($random(seed));
         repeat (3) @(posedge pclk);
         exp_data = m[2] ? 16'ha5a5 : adc_result;
         exp_tag  = m[1:0] == 2'h1 ? adc_chan : (m[1:0] == 2'h2 ? 4'h8 : 4'h0);
         `CHK("out_word", {exp_data, exp_tag}, out_word)
      end
      wr(8'h04, 8'h01, 1'b0);
      repeat (6) @(posedge pclk);
      rd(8'h00, 8'hc5, 1'b0);
      rd(8'h04, 8'h00, 1'b0);
      rd(8'h08, 8'h00, 1'b0);
      `CHK("outs after reset", 10'h000, {gen_outs, dat_outs})
      wr(8'h00, 8'h01, 1'b0);
      config_load_crc_bad <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(8'h00, 8'hc4, 1'b0);
      bump(1'b1);
      rd(8'h00, 8'hc1, 1'b0);
      wr(8'h00, 8'h01, 1'b0);
      bump(1'b0);
      rd(8'h00, 8'hc1, 1'b0);
      `CHK("irq masked", 1'b0, irq)
      rd(8'h0c, 8'h02, 1'b0);
      wr(8'h10, 8'h02, 1'b0);
      repeat (2) @(posedge pclk);
      `CHK("irq", 1'b1, irq)
      wr(8'h0c, 8'h02, 1'b0);
      repeat (2) @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      rd(8'h0c, 8'h00, 1'b0);
      wr(8'h00, 8'h01, 1'b0);
      wr(8'h04, 8'h40, 1'b0);
      wr(8'h10, 8'h01, 1'b0);
      for (m = 0; m < 4; m++)
      begin
         wr(8'h08, 8'(m), 1'b0);
         u_asc_spi_host.send_frame(m[1:0], 1'b0);
         rd(8'h00, 8'hc0, 1'b0);
         u_asc_spi_host.send_frame(m[1:0], 1'b1);
         repeat (10) @(posedge pclk);
         rd(8'h00, 8'hc2, 1'b0);
         `CHK("irq crc", 1'b1, irq)
         wr(8'h08, 8'h80, 1'b1);
         wr(8'h10, 8'h00, 1'b1);
         rd(8'h08, 8'(m), 1'b0);
         wr(8'h00, 8'h02, 1'b0);
         wr(8'h0c, 8'h01, 1'b0);
         rd(8'h00, 8'hc0, 1'b0);
      end
      wr(8'h04, 8'h00, 1'b0);
      u_asc_spi_host.send_frame(2'h0, 1'b1);
      repeat (10) @(posedge pclk);
      rd(8'h00, 8'hc0, 1'b0);
      repeat (2) @(posedge pclk);
      `CHK("notes left", 0, notes.size())
      tally_and_finish();
   end
endmodule : tb_top
